//--- src/cmp_ctrl_pkg.sv
// Package: register map, field positions and reset values of the comparator block
package cmp_ctrl_pkg;
   localparam logic [11:0] ctrl_offset = 12'h000;
   localparam logic [11:0] status_offset = 12'h004;
   localparam logic [11:0] mask_offset = 12'h008;
   localparam logic [11:0] mode_offset = 12'h00c;
   localparam logic [11:0] port_offset = 12'h010;
   localparam int sel_bit = 7;
   localparam int pwr_bit = 6;
   localparam int inv_bit = 5;
   localparam int res_bit = 4;
   localparam int path_bit = 3;
   localparam int edge_hi_bit = 2;
   localparam int edge_lo_bit = 1;
   localparam int hys_bit = 0;
   localparam logic [7:0] ctrl_reset = 8'h81;
   localparam logic [7:0] ctrl_wmask = 8'hef;
   localparam logic [1:0] edge_rise = 2'h0;
   localparam logic [1:0] edge_fall = 2'h1;
   localparam logic [1:0] mode_run = 2'h0;
   localparam logic [1:0] mode_idle = 2'h1;
   localparam logic [1:0] mode_sleep = 2'h2;
endpackage

//--- src/cmp_sync.sv
// Two-flop synchroniser for the comparator core output
`timescale 1ns/100ps
`default_nettype none
module cmp_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic d,
   output logic q
);
   typedef struct packed {
      logic s1;
      logic s2;
   } sync_s;
   sync_s st_r;
   sync_s st_nxt;
   always_comb begin
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign q = st_r.s2;
endmodule // cmp_sync
`default_nettype wire

//--- src/analog_comparator_control.sv
// Comparator control register, edge interrupt, wake-up and pin muxing
// Notes on behaviour
// - Select bit hands two pins to comparator
// - Selected pins drop their pull-high resistors
// - Power bit switches comparator core on/off
// - Invert bit inverts the stored result
// - Result bit reads polarity-adjusted comparison
// - Clear path bit routes result to output pin
// - Edge field picks rising, falling or both
// - Hysteresis bit enables core feedback
// - Qualifying change sets flag; enable raises interrupt
// - Edges come from result bit, not pin
// - Flag set in sleep/idle wakes the device while the power bit is set
// - Enabled comparator stays on in sleep/idle
// - Shared pin reads give zero or port data while the select and power bits are both set
`timescale 1ns/100ps
`default_nettype none
module analog_comparator_control
   import cmp_ctrl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic core_out,
   input wire logic [1:0] pin_in,
   output logic core_power_on,
   output logic core_hysteresis_on,
   output logic [1:0] input_pins_connect,
   output logic [1:0] pull_high_allow,
   output logic result_output_pin,
   output logic result_output_pin_oe,
   output logic wake_up,
   output logic irq
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic flag;
      logic mask;
      logic [1:0] mode;
      logic [1:0] port_ctl;
      logic [1:0] port_dat;
      logic [1:0] pull_en;
      logic res_prev;
      logic [31:0] rdata;
   } state_s;
   state_s st_r;
   state_s st_nxt;
   logic core_sync;
   logic result;
   logic rise;
   logic fall;
   logic edge_hit;
   logic wr;
   logic rd;
   logic sel_ok;
   logic [1:0] pin_s1_r;
   logic [1:0] pin_s2_r;

   cmp_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(core_out),
      .q(core_sync)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_r <= 2'h0;
         pin_s2_r <= 2'h0;
      end else begin
         pin_s1_r <= pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end

   function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [7:0] nw,
                                        input logic en);
      merge8 = en ? nw : old;
   endfunction

   // Stored result, forced low while the core is off
   assign result = st_r.ctrl[pwr_bit] &
                   (core_sync ^ st_r.ctrl[inv_bit]);
   assign rise = result & ~st_r.res_prev;
   assign fall = ~result & st_r.res_prev;
   always_comb begin
      if (st_r.ctrl[edge_hi_bit]) begin
         edge_hit = rise | fall;
      end else if (st_r.ctrl[edge_hi_bit:edge_lo_bit] == edge_fall) begin
         edge_hit = fall;
      end else begin
         edge_hit = rise;
      end
   end

   assign sel_ok = paddr == ctrl_offset || paddr == status_offset ||
                   paddr == mask_offset || paddr == mode_offset ||
                   paddr == port_offset;
   assign wr = psel & penable & pwrite & sel_ok;
   assign rd = psel & ~penable & ~pwrite;

   always_comb begin
      st_nxt = st_r;
      st_nxt.res_prev = result;
      if (wr && pstrb[0]) begin
         unique case (paddr)
            ctrl_offset: st_nxt.ctrl = (pwdata[7:0] & ctrl_wmask) |
                                       (st_r.ctrl & ~ctrl_wmask);
            status_offset: st_nxt.flag = pwdata[0];
            mask_offset: st_nxt.mask = pwdata[0];
            mode_offset: st_nxt.mode = pwdata[1:0];
            port_offset: begin
               st_nxt.port_ctl = pwdata[1:0];
               st_nxt.port_dat = pwdata[3:2];
               st_nxt.pull_en = pwdata[5:4];
            end
            default: st_nxt.ctrl = merge8(st_r.ctrl, st_r.ctrl, 1'b0);
         endcase
      end
      st_nxt.ctrl[res_bit] = result;
      // Read of status clears the flag one cycle after setup
      if (psel && penable && !pwrite && paddr == status_offset) begin
         st_nxt.flag = 1'b0;
      end
      if (edge_hit) begin
         st_nxt.flag = 1'b1;
      end
      st_nxt.rdata = 32'h0;
      if (rd) begin
         unique case (paddr)
            ctrl_offset: st_nxt.rdata = {24'h0, st_r.ctrl};
            status_offset: st_nxt.rdata = {31'h0, st_r.flag};
            mask_offset: st_nxt.rdata = {31'h0, st_r.mask};
            mode_offset: st_nxt.rdata = {30'h0, st_r.mode};
            port_offset: begin
               if (st_r.ctrl[sel_bit] && st_r.ctrl[pwr_bit]) begin
                  st_nxt.rdata = {26'h0, st_r.pull_en,
                     st_r.port_dat & ~st_r.port_ctl,
                     st_r.port_ctl};
               end else begin
                  st_nxt.rdata = {26'h0, st_r.pull_en, pin_s2_r,
                     st_r.port_ctl};
               end
            end
            default: st_nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.ctrl <= ctrl_reset;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~sel_ok;
   // Core stays on in every mode while enabled
   assign core_power_on = st_r.ctrl[pwr_bit];
   assign core_hysteresis_on = st_r.ctrl[hys_bit];
   assign input_pins_connect = {2{st_r.ctrl[sel_bit]}};
   assign pull_high_allow = st_r.pull_en &
                            ~{2{st_r.ctrl[sel_bit]}};
   assign result_output_pin = st_r.ctrl[res_bit];
   assign result_output_pin_oe = ~st_r.ctrl[path_bit];
   assign wake_up = st_r.flag & st_r.ctrl[pwr_bit] &
                    (st_r.mode != mode_run);
   assign irq = st_r.flag & st_r.mask;

   a_pin_pull_off: assert property (@(posedge pclk) disable iff (!presetn)
      st_r.ctrl[sel_bit] |-> pull_high_allow == 2'h0)
      else $error("pull-high active on selected pins");
   a_rise_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.ctrl[2:1] == edge_rise && rise) |=> st_r.flag)
      else $error("rising edge did not set flag");
   a_fall_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.ctrl[2:1] == edge_fall && fall) |=> st_r.flag)
      else $error("falling edge did not set flag");
   a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.flag && !psel) |=> st_r.flag)
      else $error("flag dropped without software");
   a_result_pol: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(core_sync) && st_r.ctrl[pwr_bit] && !st_r.ctrl[inv_bit]
      && !$changed(st_r.ctrl[inv_bit])
      |=> ##1 st_r.ctrl[res_bit])
      else $error("result bit not following core");
   a_irq_mask: assert property (@(posedge pclk) disable iff (!presetn)
      irq == (st_r.flag && st_r.mask))
      else $error("irq mismatch");
   a_wake_sleep: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.mode == mode_sleep && st_r.flag && st_r.ctrl[pwr_bit])
      |-> wake_up)
      else $error("no wake-up");
   a_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
      st_r.ctrl[path_bit] |-> !result_output_pin_oe)
      else $error("pin driven in internal mode");
   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !sel_ok) |-> pslverr)
      else $error("no error on unmapped access");
endmodule // analog_comparator_control
`default_nettype wire

//--- tb/cmp_core_model.sv
// Behavioural model of the analog comparator core
`timescale 1ns/100ps
`default_nettype none
module cmp_core_model (
   input wire logic power_on,
   input wire logic above,
   output logic core_out
);
   // Unpowered core gives a low output
   assign core_out = power_on & above;
endmodule // cmp_core_model
`default_nettype wire

//--- tb/tb_analog_comparator_control.sv
// Self-checking bench for the comparator control block
`timescale 1ns/100ps
`default_nettype none
module tb_analog_comparator_control;
   import cmp_ctrl_pkg::*;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic above = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] lfsr = 32'hc9a9;
   logic [1:0] pin_in = 2'h0;
   logic [31:0] prdata;
   logic pready, pslverr, core_out, pwr_on, hys_on;
   logic out_pin, out_oe, wake_up, irq;
   logic [1:0] pins_conn, pull_allow;
   logic [31:0] exp_q[$];
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;

   analog_comparator_control analog_comparator_control_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_out(core_out), .pin_in(pin_in), .core_power_on(pwr_on),
      .core_hysteresis_on(hys_on), .input_pins_connect(pins_conn),
      .pull_high_allow(pull_allow), .result_output_pin(out_pin),
      .result_output_pin_oe(out_oe), .wake_up(wake_up), .irq(irq));

   cmp_core_model cmp_core_model_inst (
      .power_on(pwr_on), .above(above), .core_out(core_out));

   initial begin
      forever #50 pclk = ~pclk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic final_report;
      if (errors == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      samples_checked++;
      if (seen !== expd) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic settle;
      repeat (6) @(posedge pclk);
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
         check(prdata, exp_q.pop_front());
      if (psel && penable && pready)
         check(pslverr, paddr == 12'h020);
      cycles++;
      lfsr <= lfsr_next(lfsr);
      pin_in <= lfsr[1:0];
      if (cycles == 4000) begin
         errors++;
         final_report();
      end
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(ctrl_offset, 32'h81);
      check({pins_conn, pull_allow, pwr_on, hys_on, out_oe}, 32'h63);
      apb(1'b1, mask_offset, 32'h1);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, ctrl_offset, 32'hc0 | (c << 1));
         above <= 1'b0;
         settle;
         apb(1'b1, status_offset, 32'h0);
         above <= 1'b1;
         settle;
         check(irq, c != 1);
         rd(status_offset, c != 1);
         rd(ctrl_offset, 32'hd0 | (c << 1));
         above <= 1'b0;
         settle;
         rd(status_offset, c != 0);
      end
      apb(1'b1, ctrl_offset, 32'he4);
      settle;
      rd(ctrl_offset, 32'hf4);
      check({out_pin, out_oe}, 32'h3);
      apb(1'b1, mode_offset, 32'h2);
      apb(1'b1, ctrl_offset, 32'hec);
      apb(1'b1, status_offset, 32'h0);
      above <= 1'b1;
      settle;
      check({wake_up, pwr_on, out_oe, irq}, 32'hd);
      rd(ctrl_offset, 32'hec);
      apb(1'b1, mask_offset, 32'h0);
      settle;
      check(irq, 32'h0);
      apb(1'b1, port_offset, 32'h3e);
      settle;
      check(pull_allow, 32'h0);
      rd(port_offset, 32'h36);
      apb(1'b1, status_offset, 32'h1);
      rd(status_offset, 32'h1);
      apb(1'b1, ctrl_offset, 32'h80);
      settle;
      check({pwr_on, core_out}, 32'h0);
      rd(12'h020, 32'h0);
      settle;
      final_report();
   end
endmodule // tb_analog_comparator_control
`default_nettype wire
